// *** rtl/hib_top.v ***
// harmonic inrush blocking: detection, mode timing, stage blocking, registers
//
// Notes on behaviour
// R01: per phase, flag inrush when second harmonic ratio strictly exceeds threshold
// R02: threshold settable ten to fifty percent in one percent steps
// R03: detection only when fundamental is at least 0.2 nominal; no upper limit
// R04: mode 1 continuous detection, mode 2 armed only after breaker close
// R05: continuous mode starts minimum inhibit timer on detection, 0 to 200 s
// R06: inrush ending early keeps stages blocked until inhibit timer expires
// R07: inrush outlasting inhibit timer keeps blocking while inrush persists
// R08: close mode blocks after own close command while window runs and inrush
// R09: close mode also applies the minimum inhibit timer
// R10: blocking not phase selective; any phase blocks all three
// R11: stage blocked only when its trip mode equals 3
// R12: selected stage starts are reset while blocking is asserted
// R13: configurer should leave high set stage unselected in transformer use
// R14: ratio evaluated once per upstream measurement update
`timescale 1ns/1ns
`include "hib_consts.vh"
module hib_top (
    clk,
    reset,
    meas_valid,
    phase_a_current,
    phase_b_current,
    phase_c_current,
    phase_a_h2,
    phase_b_h2,
    phase_c_h2,
    close_cmd,
    stage_start_in,
    stage_start_out,
    inrush_block,
    phase_inrush,
    irq,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata
);
    input wire clk;
    input wire reset;
    input wire meas_valid;
    input wire [15:0] phase_a_current;
    input wire [15:0] phase_b_current;
    input wire [15:0] phase_c_current;
    input wire [15:0] phase_a_h2;
    input wire [15:0] phase_b_h2;
    input wire [15:0] phase_c_h2;
    input wire close_cmd;
    input wire [9:0] stage_start_in;
    output reg [9:0] stage_start_out;
    output reg inrush_block;
    output reg [2:0] phase_inrush;
    output reg irq;
    input wire [3:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [31:0] reg_rdata;

    // settings and interrupt status
    reg [1:0] mode_q;
    reg [6:0] ratio_q;
    reg [17:0] inhibit_ms_q;
    reg [17:0] window_ms_q;
    reg [15:0] nominal_q;
    reg [19:0] trip_mode_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;

    wire [15:0] fund [0:2];
    wire [15:0] harm [0:2];
    assign fund[0] = phase_a_current;
    assign fund[1] = phase_b_current;
    assign fund[2] = phase_c_current;
    assign harm[0] = phase_a_h2;
    assign harm[1] = phase_b_h2;
    assign harm[2] = phase_c_h2;

    // 0.2 In compare done as 5*fund >= nominal to avoid a divider
    wire [2:0] det_d;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_phase
            wire [18:0] fund_x5;
            wire [18:0] nom_x1;
            wire [22:0] h2_x100;
            wire [22:0] thr_prod;
            assign fund_x5 = {3'h0, fund[g]} + {1'b0, fund[g], 2'h0};
            assign nom_x1 = {3'h0, nominal_q};
            assign h2_x100 = {1'b0, harm[g], 6'h00} + {2'h0, harm[g], 5'h00}
                + {5'h00, harm[g], 2'h0};
            assign thr_prod = fund[g] * ratio_q;
            assign det_d[g] = (fund_x5 >= nom_x1) && (h2_x100 > thr_prod); // R01 R03
        end
    endgenerate

    // ratio only re-evaluated on a fresh measurement
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_inrush <= 3'h0;
        end else if (meas_valid) begin
            phase_inrush <= det_d; // R14
        end
    end

    wire any_inrush = |phase_inrush; // R10

    // millisecond tick prescaler
    reg [17:0] pre_q;
    wire tick_ms = (pre_q == 18'h00000);
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_q <= 18'h00000;
        end else if (tick_ms) begin
            // reload is one less than the divider so a tick lands every 1 ms
            pre_q <= `HIB_MS_RELOAD;
        end else begin
            pre_q <= pre_q - 18'h00001;
        end
    end

    // inhibit timer restarts on each rising inrush edge while armed
    reg inrush_prev_q;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            inrush_prev_q <= 1'b0;
        end else begin
            inrush_prev_q <= any_inrush;
        end
    end
    wire inrush_rise = any_inrush && !inrush_prev_q;
    wire mode_cont = (mode_q == `HIB_MODE_CONT);
    wire mode_close = (mode_q == `HIB_MODE_CLOSE);
    wire window_run;
    wire inhibit_run;
    wire armed = mode_cont || (mode_close && window_run); // R04 R08
    wire inhibit_load = inrush_rise && armed; // R05 R09

    hib_ms_timer u_inhibit (
        .clk(clk),
        .reset(reset),
        .tick_ms(tick_ms),
        .load(inhibit_load),
        .load_ms(inhibit_ms_q),
        .running(inhibit_run)
    );

    hib_ms_timer u_window (
        .clk(clk),
        .reset(reset),
        .tick_ms(tick_ms),
        .load(close_cmd && mode_close), // R08
        .load_ms(window_ms_q),
        .running(window_run)
    );

    // early end held by timer; long inrush held by the condition itself
    wire block_d = (any_inrush && armed) || inhibit_run; // R06 R07 R09

    wire [9:0] sel;
    generate
        for (g = 0; g < 10; g = g + 1) begin : g_stage
            assign sel[g] = (trip_mode_q[2*g+1:2*g] == `HIB_TRIP_MODE_HB); // R11
        end
    endgenerate

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            inrush_block <= 1'b0;
            stage_start_out <= 10'h000;
        end else begin
            inrush_block <= block_d;
            stage_start_out <= block_d ? (stage_start_in & ~sel) : stage_start_in; // R12
        end
    end

    // interrupts: set wins over clear
    wire [2:0] ev = {inrush_block && !block_d, !inrush_block && block_d, inrush_rise};
    wire [2:0] clr = (reg_wr && reg_addr == `HIB_ADDR_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
            irq <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
        end
    end

    // register writes; out-of-range ratio is refused, leaving the old value
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_q <= `HIB_MODE_CONT;
            ratio_q <= `HIB_RATIO_RST;
            inhibit_ms_q <= 18'h00000;
            window_ms_q <= 18'h00000;
            nominal_q <= 16'h0000;
            trip_mode_q <= 20'h00000;
            irq_en_q <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `HIB_ADDR_CTRL: begin
                    if (reg_wdata[1:0] == `HIB_MODE_CONT || reg_wdata[1:0] == `HIB_MODE_CLOSE) begin
                        mode_q <= reg_wdata[1:0]; // R04
                    end
                end
                `HIB_ADDR_RATIO: begin
                    if (reg_wdata[31:7] == 25'h0 && reg_wdata[6:0] >= `HIB_RATIO_MIN
                        && reg_wdata[6:0] <= `HIB_RATIO_MAX) begin
                        ratio_q <= reg_wdata[6:0]; // R02
                    end
                end
                `HIB_ADDR_INHIBIT: begin
                    if (reg_wdata[31:18] == 14'h0 && reg_wdata[17:0] <= `HIB_INHIBIT_MAX_MS) begin
                        inhibit_ms_q <= reg_wdata[17:0]; // R05
                    end
                end
                `HIB_ADDR_WINDOW: window_ms_q <= reg_wdata[17:0];
                `HIB_ADDR_NOMINAL: nominal_q <= reg_wdata[15:0];
                `HIB_ADDR_TRIPMODE: trip_mode_q <= reg_wdata[19:0];
                `HIB_ADDR_IRQ_EN: irq_en_q <= reg_wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `HIB_ADDR_CTRL: reg_rdata <= {30'h0, mode_q};
                `HIB_ADDR_RATIO: reg_rdata <= {25'h0, ratio_q};
                `HIB_ADDR_INHIBIT: reg_rdata <= {14'h0, inhibit_ms_q};
                `HIB_ADDR_WINDOW: reg_rdata <= {14'h0, window_ms_q};
                `HIB_ADDR_NOMINAL: reg_rdata <= {16'h0, nominal_q};
                `HIB_ADDR_TRIPMODE: reg_rdata <= {12'h0, trip_mode_q};
                `HIB_ADDR_STATUS: reg_rdata <= {26'h0, window_run, inhibit_run,
                    inrush_block, phase_inrush};
                `HIB_ADDR_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_q};
                `HIB_ADDR_IRQ_EN: reg_rdata <= {29'h0, irq_en_q};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// *** rtl/hib_consts.vh ***
// constants for the harmonic inrush blocking block
`ifndef HIB_CONSTS_VH
`define HIB_CONSTS_VH
`define HIB_MAG_W 16
`define HIB_NSTAGE 10
`define HIB_MODE_CONT 2'h1
`define HIB_MODE_CLOSE 2'h2
`define HIB_TRIP_MODE_HB 2'h3
`define HIB_RATIO_MIN 7'h0A
`define HIB_RATIO_MAX 7'h32
`define HIB_RATIO_RST 7'h0F
`define HIB_INHIBIT_MAX_S 200
`define HIB_CLK_HZ 250000000
`define HIB_MS_DIV 250000
`define HIB_MS_RELOAD 18'h3D08F
`define HIB_INHIBIT_MAX_MS 18'h30D40
`define HIB_ADDR_CTRL 4'h0
`define HIB_ADDR_RATIO 4'h1
`define HIB_ADDR_INHIBIT 4'h2
`define HIB_ADDR_WINDOW 4'h3
`define HIB_ADDR_NOMINAL 4'h4
`define HIB_ADDR_TRIPMODE 4'h5
`define HIB_ADDR_STATUS 4'h6
`define HIB_ADDR_IRQ_STAT 4'h7
`define HIB_ADDR_IRQ_CLR 4'h8
`define HIB_ADDR_IRQ_EN 4'h9
`define HIB_IRQ_DET 0
`define HIB_IRQ_BLK_ON 1
`define HIB_IRQ_BLK_OFF 2
`define HIB_IRQ_W 3
`endif

// *** rtl/hib_ms_timer.v ***
// millisecond down-counter timer used for inhibit and close window
`timescale 1ns/1ns
`include "hib_consts.vh"
module hib_ms_timer (
    clk,
    reset,
    tick_ms,
    load,
    load_ms,
    running
);
    input wire clk;
    input wire reset;
    input wire tick_ms;
    input wire load;
    input wire [17:0] load_ms;
    output reg running;

    reg [17:0] cnt_q;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 18'h00000;
            running <= 1'b0;
        end else if (load) begin
            cnt_q <= load_ms;
            running <= (load_ms != 18'h00000);
        end else if (tick_ms && running) begin
            cnt_q <= cnt_q - 18'h00001;
            running <= (cnt_q != 18'h00001);
        end
    end
endmodule

// *** dv/hib_far_model.sv ***
// far side: breaker close command logic and protection stage start sources
`timescale 1ns/1ns
module hib_far_model (
    input wire clk,
    input wire close_req,
    input wire [9:0] starts,
    output reg close_cmd = 1'b0,
    output reg [9:0] stage_start_in = 10'h000
);
    // registered so every change lands just after an edge, as real timers do
    always @(posedge clk) begin
        close_cmd <= close_req;
        stage_start_in <= starts;
    end
endmodule

// *** dv/hib_checker.sv ***
// port assertions for the inrush blocking block
`timescale 1ns/1ns
module hib_checker (
    input wire clk,
    input wire reset,
    input wire meas_valid,
    input wire [9:0] stage_start_in,
    input wire [9:0] stage_start_out,
    input wire inrush_block,
    input wire [2:0] phase_inrush,
    input wire [3:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_nos; (stage_start_out & ~$past(stage_start_in)) == 10'h000; endproperty
    a_nos: assert property (p_nos) else $error("start made up");
    // skip the edge after reset: the output register still holds its cleared value
    property p_pass; !inrush_block && !$past(reset) |-> stage_start_out == $past(stage_start_in);
    endproperty
    a_pass: assert property (p_pass) else $error("start masked while free");
    property p_meas; !$past(meas_valid) |-> $stable(phase_inrush); endproperty
    a_meas: assert property (p_meas) else $error("detection moved alone");
    property p_cause; $rose(inrush_block) |-> $past(|phase_inrush); endproperty
    a_cause: assert property (p_cause) else $error("block without inrush");
    property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h00000000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_stat; $past(reg_rd && reg_addr == 4'h6) |->
        reg_rdata[3:0] == {$past(inrush_block), $past(phase_inrush)}; endproperty
    a_stat: assert property (p_stat) else $error("status mismatch");
    property p_unm; $past(reg_rd && reg_addr > 4'h9) |-> reg_rdata == 32'h00000000; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_irqr; $past(reg_rd && reg_addr == 4'h7) |-> reg_rdata[31:3] == 29'h0; endproperty
    a_irqr: assert property (p_irqr) else $error("irq status upper bits");
    c_blk: cover property ($rose(inrush_block));
    c_mask: cover property (inrush_block && stage_start_out != stage_start_in);
    c_det: cover property ($rose(|phase_inrush));
endmodule
bind hib_top hib_checker i_chk (.clk(clk), .reset(reset), .meas_valid(meas_valid),
    .stage_start_in(stage_start_in), .stage_start_out(stage_start_out),
    .inrush_block(inrush_block), .phase_inrush(phase_inrush), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// *** dv/testbench.sv ***
// self-checking bench for inrush blocking
`timescale 1ns/1ns
module testbench;
    reg clk = 1'b0, reset = 1'b1, mv = 1'b0, cr = 1'b0, ws = 1'b0, rs = 1'b0;
    reg [3:0] ad = 4'h0;
    reg [31:0] wd = 32'h0;
    reg [47:0] f = 48'h0, h = 48'h0;
    reg [9:0] st = 10'h3FF;
    wire cc, irq, blk;
    wire [2:0] ph;
    wire [9:0] si, so;
    wire [31:0] rdat;
    integer miscompares = 0, samples_checked = 0, p;
    always #2 clk = ~clk;
    hib_far_model i_far (.clk(clk), .close_req(cr), .starts(st), .close_cmd(cc),
        .stage_start_in(si));
    hib_top i_dut (.clk(clk), .reset(reset), .meas_valid(mv), .phase_a_current(f[15:0]),
        .phase_b_current(f[31:16]), .phase_c_current(f[47:32]), .phase_a_h2(h[15:0]),
        .phase_b_h2(h[31:16]), .phase_c_h2(h[47:32]), .close_cmd(cc), .stage_start_in(si),
        .stage_start_out(so), .inrush_block(blk), .phase_inrush(ph), .irq(irq),
        .reg_addr(ad), .reg_wdata(wd), .reg_wr(ws), .reg_rd(rs), .reg_rdata(rdat));
    task chk(input [31:0] g, input [31:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one task for both strobes; a read compares d against the data
    task acc(input w, input [3:0] a, input [31:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        {ws, rs} <= {w, !w};
        @(posedge clk);
        {ws, rs} <= 2'b00;
        #1;
        if (!w) chk(rdat, d);
    endtask
    task meas(input [15:0] fv, input [15:0] hv, input [2:0] m);
        @(posedge clk);
        f <= {3{fv}};
        h <= {m[2] ? hv : 16'h0, m[1] ? hv : 16'h0, m[0] ? hv : 16'h0};
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_regs;
        acc(1, 4'h1, 32'h9);
        acc(0, 4'h1, 32'hF);
        acc(1, 4'h1, 32'h33);
        acc(0, 4'h1, 32'hF);
        acc(1, 4'h0, 32'h3);
        acc(0, 4'h0, 32'h1);
        acc(0, 4'hF, 32'h0);
        $display("regs done");
    endtask
    task t_det;
        acc(1, 4'h1, 32'h14);
        acc(1, 4'h4, 32'h1388);
        meas(16'h3E8, 16'hC8, 3'h7);
        chk(ph, 3'h0);
        meas(16'h3E8, 16'hC9, 3'h1);
        chk(ph, 3'h1);
        meas(16'h3E7, 16'h1F4, 3'h7);
        chk(ph, 3'h0);
        meas(16'hFFFF, 16'h4000, 3'h4);
        chk(ph, 3'h4);
        $display("detect done");
    endtask
    task t_blk;
        acc(1, 4'h5, 32'hF);
        for (p = 0; p < 3; p = p + 1) begin
            meas(16'h3E8, 16'h1F4, 3'h1 << p);
            chk({blk, so}, 11'h7FC);
            meas(16'h3E8, 16'h0, 3'h0);
            chk({blk, so}, 11'h3FF);
        end
        $display("block done");
    endtask
    task t_irq;
        acc(1, 4'h8, 32'h7);
        meas(16'h3E8, 16'h1F4, 3'h2);
        chk(irq, 1'b0);
        acc(0, 4'h7, 32'h3);
        acc(1, 4'h9, 32'h7);
        @(posedge clk);
        #1;
        chk(irq, 1'b1);
        meas(16'h3E8, 16'h0, 3'h0);
        acc(1, 4'h8, 32'h7);
        acc(0, 4'h7, 32'h0);
        chk(irq, 1'b0);
        $display("irq done");
    endtask
    task t_hold;
        acc(1, 4'h2, 32'h2);
        meas(16'h3E8, 16'h1F4, 3'h1);
        meas(16'h3E8, 16'h0, 3'h0);
        repeat (1000) @(posedge clk);
        #1;
        chk({blk, ph}, 4'h8);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        acc(0, 4'h2, 32'h0);
        chk(blk, 1'b0);
        $display("hold done");
    endtask
    task t_close;
        acc(1, 4'h3, 32'h2);
        acc(1, 4'h0, 32'h2);
        meas(16'h3E8, 16'h1F4, 3'h1);
        chk(blk, 1'b0);
        @(posedge clk);
        cr <= 1'b1;
        @(posedge clk);
        cr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(blk, 1'b1);
        meas(16'h3E8, 16'h0, 3'h0);
        chk(blk, 1'b0);
        $display("close done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_det;
        t_blk;
        t_irq;
        t_hold;
        t_close;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        give_verdict;
    end
endmodule
